// file: sim/fpc_far_model.sv
/* Far-side consumer of the drain stream of the block.
   Assumes the bench steers its pace through stall. */
`timescale 1ns/100ps
module fpc_far_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    output logic out_ready,
    output logic [7:0] rx_last,
    output logic [7:0] rx_cnt
);
    // Accept words only while not stalled
    assign out_ready = !stall;
    // Record every word taken by the handshake
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_cnt <= 8'h00;
            rx_last <= 8'h00;
        end else if (out_valid && out_ready) begin
            rx_cnt <= rx_cnt + 8'h01;
            rx_last <= out_data;
        end
    end
endmodule // fpc_far_model

// file: sim/fpc_regs_sva.sv
/* Port-level assertions for the per-port control register block.
   Assumes one clock domain and attachment to fpc_regs by the bind at the foot. */
`timescale 1ns/100ps
module fpc_regs_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire fpc_pkg::fpc_bus_type p1_bus,
    input wire fpc_pkg::fpc_bus_type p2_bus,
    input wire fpc_pkg::fpc_acc_type p1_acc,
    input wire fpc_pkg::fpc_acc_type p2_acc,
    input wire logic [7:0] p1_rdata,
    input wire logic [7:0] p2_rdata,
    input wire logic fifo_clear,
    input wire logic p1_flow_oe_b,
    input wire logic port_two_handshake_strobe,
    input wire logic p2_float,
    input wire logic p1_pattern_match
);
    import fpc_pkg::*;
    logic [3:0] ix1;
    logic [3:0] ix2;
    logic ok1;
    logic ok2;
    // Register index wherever the bus form fixes it without the alignment bit
    assign ix1 = (p1_bus == FPC_BUS_MUX_HIGH) ? p1_acc.hi_index : p1_acc.addr[3:0];
    assign ix2 = (p2_bus == FPC_BUS_MUX_HIGH) ? p2_acc.hi_index : p2_acc.addr[3:0];
    assign ok1 = p1_bus != FPC_BUS_MUX_LOW;
    assign ok2 = p2_bus != FPC_BUS_MUX_LOW;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // Steps of the message, freeze and mask behaviour
    sequence msg_sent;
        p1_acc.wr && ok1 && ix1 == REG_MSG_OUT;
    endsequence
    sequence ctrl1_seen;
        ok1 && ix1 == REG_CTRL1 && !p1_acc.wr;
    endsequence
    sequence count_read;
        p1_acc.rd && !p1_acc.wr && ok1 && ix1 == REG_FCOUNT;
    endsequence
    sequence mask_all;
        p1_acc.wr && ok1 && ix1 == REG_MASK && p1_acc.wdata == 8'hFF;
    endsequence
    reset_state_a: assert property ($rose(rst_b) |-> fifo_clear && p2_float
        && port_two_handshake_strobe && p1_flow_oe_b)
        else $error("outputs not idle after reset release");
    ctrl1_top_a: assert property (ctrl1_seen |-> !p1_rdata[7])
        else $error("control one bit 7 reads one");
    ctrl2_high_a: assert property (ok1 && ix1 == REG_CTRL2 |-> p1_rdata[7:2] == 6'h00)
        else $error("control two upper bits not zero");
    p2_ctrl2_a: assert property (ok2 && ix2 == REG_CTRL2 |-> p2_rdata == 8'h00)
        else $error("port 2 control two read not zero");
    ctrl3_gap_a: assert property (ok1 && ix1 == REG_CTRL3 |-> !p1_rdata[2])
        else $error("control three bit 2 reads one");
    compare_top_a: assert property (ok1 && ix1 == REG_FCMP |-> !p1_rdata[7])
        else $error("compare bit 7 reads one");
    count_max_a: assert property (ok1 && ix1 == REG_FCOUNT |-> p1_rdata <= COUNT_MAX)
        else $error("byte count above limit");
    msg_full_a: assert property (msg_sent ##1 !p2_acc.rd ##1 ctrl1_seen |-> p1_rdata[C1_MSG_FULL])
        else $error("message full flag not set after write");
    freeze_drop_a: assert property (count_read ##1 !p1_acc.wr ##1 ctrl1_seen |-> !p1_rdata[C1_FREEZE])
        else $error("freeze bit kept after count read");
    p2_quiet_a: assert property (p2_float |-> p2_rdata == 8'h00)
        else $error("floating port 2 returns data");
    mask_match_a: assert property (mask_all ##1 !p1_acc.wr |-> ##[0:1] p1_pattern_match)
        else $error("full mask gives no match");
endmodule // fpc_regs_sva

bind fpc_regs fpc_regs_sva u_sva (.clk(clk), .rst_b(rst_b), .p1_bus(p1_bus), .p2_bus(p2_bus), .p1_acc(p1_acc),
    .p2_acc(p2_acc), .p1_rdata(p1_rdata), .p2_rdata(p2_rdata), .fifo_clear(fifo_clear), .p1_flow_oe_b(p1_flow_oe_b),
    .port_two_handshake_strobe(port_two_handshake_strobe), .p2_float(p2_float), .p1_pattern_match(p1_pattern_match));

// file: sim/tb_fpc_regs.sv
/* Self-checking bench for the per-port control register block.
   Assumes the checker is bound in and the far model drains the buffer. */
`timescale 1ns/100ps
module tb_fpc_regs;
    import fpc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    fpc_bus_type p1_bus = FPC_BUS_NONMUX;
    fpc_bus_type p2_bus = FPC_BUS_NONMUX;
    fpc_acc_type p1_acc = '0;
    fpc_acc_type p2_acc = '0;
    logic in_valid = 1'b0, fifo_push = 1'b0, fifo_pop = 1'b0, p1_is = 1'b0, p2_is = 1'b0, p2_in0 = 1'b0, stall = 1'b1;
    logic [7:0] in_data = 8'h00;
    logic [7:0] p1_rdata, p2_rdata, out_data, cmatch, rx_last, rx_cnt, rv, d;
    logic in_ready, out_valid, out_ready, fifo_clear, f1o, f1e, hs, p2_float, pmatch, full, f2o, f2e, dir1, dir2;
    logic [3:0] ix;
    logic [3:0] tbl [6] = '{REG_CTRL1, REG_CTRL2, REG_FCMP, REG_PATTERN, REG_MASK, REG_MSG_OUT};
    fpc_p2io_type p2io;
    int error_cnt = 0, n_checks = 0, seed = 32'h4b6a08d3;
    fpc_regs uut (.clk, .rst_b, .p1_bus, .p2_bus, .p1_acc, .p2_acc, .p1_rdata, .p2_rdata, .in_valid, .in_ready,
        .in_data, .out_valid, .out_ready, .out_data, .fifo_push, .fifo_pop, .fifo_clear, .p1_in_service(p1_is),
        .p2_in_service(p2_is), .p1_flow_out(f1o), .p1_flow_oe_b(f1e), .p2_flow_out(f2o), .p2_flow_oe_b(f2e),
        .port_two_handshake_strobe(hs), .p2_float, .p2io, .p2_in0, .p1_dir(dir1), .p2_dir(dir2),
        .p1_count_match(cmatch), .p1_pattern_match(pmatch));
    fpc_far_model far (.clk, .rst_b, .stall, .out_valid, .out_data, .out_ready, .rx_last, .rx_cnt);
    // Free-running clock, 8 ns period
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // One register access on either port, held for one cycle; read data taken at the sampling edge
    task automatic acc(input bit p2, input bit w, input logic [7:0] a, input logic [7:0] wd);
        @(posedge clk);
        if (p2) p2_acc <= '{rd: !w, wr: w, addr: a, hi_index: a[7:4], wdata: wd};
        else p1_acc <= '{rd: !w, wr: w, addr: a, hi_index: a[7:4], wdata: wd};
        @(posedge clk);
        rv = p2 ? p2_rdata : p1_rdata;
        p1_acc <= '0;
        p2_acc <= '0;
    endtask
    task automatic wreg(input bit p2, input logic [3:0] i, input logic [7:0] v);
        acc(p2, 1'b1, {4'h0, i}, v);
    endtask
    task automatic rreg(input bit p2, input logic [3:0] i, input logic [7:0] exp);
        acc(p2, 1'b0, {4'h0, i}, 8'h00);
        chk(rv, exp);
    endtask
    // Push or pop strobes for n cycles in a row
    task automatic pulse(input bit pop, input int n);
        repeat (n) begin
            @(posedge clk);
            {fifo_pop, fifo_push} <= {pop, !pop};
        end
        @(posedge clk);
        {fifo_pop, fifo_push} <= 2'b00;
    endtask
    // Offer one word and hold it until the buffer takes it
    task automatic send(input logic [7:0] v);
        @(posedge clk);
        in_valid <= 1'b1;
        in_data <= v;
        do @(posedge clk); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
    endtask
    // Read-back value of a plain register after writing v
    function automatic logic [7:0] exp_reg(input logic [3:0] i, input logic [7:0] v);
        case (i)
            REG_CTRL1: return (v & 8'h4F) | {2'b00, full, p2_is, 4'h0};
            REG_CTRL2: return v & 8'h03;
            REG_FCMP: return v & 8'h7F;
            default: return v;
        endcase
    endfunction
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done;
    end
    // Main sequence
    initial begin
        full = 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        chk({fifo_clear, p2_float, hs, f1e}, 8'h0F);
        rreg(0, REG_CTRL1, 8'h00);
        rreg(0, REG_CTRL3, 8'h00);
        rreg(1, REG_CTRL2, 8'h00);
        // Index from the right bus bits in each bus form
        p1_bus <= FPC_BUS_MUX_LOW;
        // Alignment was forced on while nonmultiplexed; clear it through index 0
        wreg(0, REG_CTRL0, 8'h00);
        acc(0, 1'b1, 8'h1A, 8'hC3);
        acc(0, 1'b0, 8'h1A, 8'h00);
        chk(rv, 8'hC3);
        wreg(0, REG_CTRL0, 8'h02);
        rreg(0, REG_PATTERN, 8'hC3);
        p1_bus <= FPC_BUS_NONMUX;
        wreg(0, REG_CTRL0, 8'h00);
        rreg(0, REG_PATTERN, 8'hC3);
        p1_bus <= FPC_BUS_MUX_HIGH;
        acc(0, 1'b0, 8'hD0, 8'h00);
        chk(rv, 8'hC3);
        p1_bus <= FPC_BUS_NONMUX;
        // Random values through the read-write registers
        for (int i = 0; i < 24; i++) begin
            ix = tbl[i % 6];
            d = $random(seed);
            wreg(0, ix, d);
            rreg(0, ix, exp_reg(ix, d));
            if (ix == REG_MSG_OUT) full = 1'b1;
            if (ix == REG_CTRL2) chk({p2_float, hs}, {!d[0], 1'b1});
        end
        // Messages both ways once port 2 is enabled
        wreg(0, REG_CTRL2, 8'h00);
        wreg(1, REG_PATTERN, 8'hA5);
        wreg(0, REG_CTRL2, 8'h01);
        rreg(1, REG_PATTERN, 8'h00);
        p2_is <= 1'b1;
        wreg(0, REG_CTRL1, 8'h00);
        d = $random(seed);
        wreg(0, REG_MSG_OUT, d);
        rreg(0, REG_CTRL1, 8'h30);
        rreg(1, REG_MSG_IN, d);
        rreg(0, REG_CTRL1, 8'h10);
        wreg(1, REG_MSG_OUT, ~d);
        rreg(0, REG_MSG_IN, ~d);
        wreg(1, REG_CTRL2, 8'h00);
        rreg(0, REG_CTRL2, 8'h01);
        // Ownership of the clear and direction bits
        wreg(0, REG_CTRL3, 8'hFB);
        rreg(1, REG_CTRL3, 8'hF0);
        chk({dir1, dir2}, 8'h02);
        wreg(1, REG_CTRL3, 8'h00);
        rreg(0, REG_CTRL3, 8'hAA);
        chk(fifo_clear, 8'h01);
        chk({dir1, dir2}, 8'h01);
        wreg(0, REG_CTRL3, 8'h5F);
        rreg(0, REG_CTRL3, 8'h0A);
        wreg(0, REG_CTRL3, 8'h40);
        rreg(0, REG_CTRL3, 8'h40);
        chk(fifo_clear, 8'h00);
        // Count: compare match, saturation, freeze, clear
        wreg(0, REG_FCMP, 8'h05);
        wreg(0, REG_CTRL1, 8'h07);
        pulse(0, 5);
        repeat (2) @(negedge clk);
        chk({cmatch[0], f1o, f1e}, 8'h04);
        pulse(0, 200);
        rreg(0, REG_FCOUNT, 8'h80);
        wreg(0, REG_CTRL1, 8'h40);
        pulse(1, 3);
        rreg(0, REG_FCOUNT, 8'h80);
        rreg(0, REG_CTRL1, 8'h10);
        rreg(0, REG_FCOUNT, 8'h7D);
        wreg(0, REG_CTRL3, 8'h00);
        rreg(0, REG_FCOUNT, 8'h00);
        wreg(0, REG_CTRL3, 8'h40);
        // Fill the buffer against a stalled receiver, then match and drain
        send(8'h3C);
        send(8'h5A);
        @(negedge clk);
        chk(in_ready, 8'h00);
        rreg(0, REG_DATA, 8'h5A);
        wreg(0, REG_PATTERN, 8'h5A);
        wreg(0, REG_MASK, 8'h00);
        wreg(0, REG_CTRL1, 8'h0B);
        repeat (2) @(negedge clk);
        chk({pmatch, f1o, f1e}, 8'h06);
        wreg(0, REG_PATTERN, 8'hA5);
        rreg(0, REG_PATTERN, 8'hA5);
        chk(pmatch, 8'h00);
        wreg(0, REG_MASK, 8'hFF);
        rreg(0, REG_MASK, 8'hFF);
        chk(pmatch, 8'h01);
        stall <= 1'b0;
        for (int k = 0; k < 20 && rx_cnt !== 8'h02; k++) @(posedge clk);
        chk({rx_cnt[1:0], out_valid, in_ready}, 8'h09);
        chk(rx_last, 8'h5A);
        // Soft reset clears controls and floats port 2
        p2_is <= 1'b0;
        wreg(0, REG_CTRL0, 8'h01);
        @(negedge clk);
        chk({p2_float, in_ready, f2o, f2e}, 8'h09);
        rreg(0, REG_CTRL2, 8'h00);
        wreg(0, REG_CTRL0, 8'h00);
        // Port 2 simple I/O bits
        wreg(0, REG_CTRL0, 8'h08);
        p2_in0 <= 1'b1;
        wreg(0, REG_CTRL3, 8'hAA);
        wreg(0, REG_CTRL2, 8'h02);
        rreg(0, REG_CTRL3, 8'hAB);
        chk({p2io.out3, p2io.out1, p2io.clr_oe_b, p2io.dir_oe_b}, 8'h0F);
        chk({p2io.clr_out, p2io.dir_out}, 8'h00);
        chk(hs, 8'h00);
        rreg(1, REG_CTRL3, 8'h00);
        test_done;
    end
endmodule // tb_fpc_regs

// file: src/fpc_pkg.sv
/*
 * Package for the per-port control and status register block of the dual-port byte buffer.
 * Assumes a single clock domain and one register access port per side of the buffer.
 */
package fpc_pkg;
    // Register indices (four bit index space)
    localparam logic [3:0] REG_CTRL0 = 4'h0;
    localparam logic [3:0] REG_CTRL1 = 4'h1;
    localparam logic [3:0] REG_FCOUNT = 4'h7;
    localparam logic [3:0] REG_FCMP = 4'h8;
    localparam logic [3:0] REG_CTRL2 = 4'h9;
    localparam logic [3:0] REG_CTRL3 = 4'hA;
    localparam logic [3:0] REG_MSG_OUT = 4'hB;
    localparam logic [3:0] REG_MSG_IN = 4'hC;
    localparam logic [3:0] REG_PATTERN = 4'hD;
    localparam logic [3:0] REG_MASK = 4'hE;
    localparam logic [3:0] REG_DATA = 4'hF;
    // Control zero fields
    localparam int C0_SOFT_RESET = 0;
    localparam int C0_ALIGN = 1;
    localparam int C0_MODE_LO = 2;
    localparam int C0_MODE_HI = 3;
    // Control one fields
    localparam int C1_FLOW_EN = 0;
    localparam int C1_REQ_SEL = 1;
    localparam int C1_START_CNT = 2;
    localparam int C1_STOP_MATCH = 3;
    localparam int C1_PEER_IUS = 4;
    localparam int C1_MSG_FULL = 5;
    localparam int C1_FREEZE = 6;
    // Control two fields
    localparam int C2_P2_EN = 0;
    localparam int C2_HS_EN = 1;
    // Control three fields
    localparam int C3_IO0 = 0;
    localparam int C3_IO1 = 1;
    localparam int C3_IO3 = 3;
    localparam int C3_DIR = 4;
    localparam int C3_DIR_OWN = 5;
    localparam int C3_CLR_N = 6;
    localparam int C3_CLR_OWN = 7;
    // Reset values and masks
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] C1_WMASK = 8'h4F;
    localparam logic [7:0] C2_MASK = 8'h03;
    localparam logic [7:0] C3_MASK = 8'hFB;
    localparam logic [7:0] FCMP_MASK = 8'h7F;
    localparam logic [7:0] COUNT_MAX = 8'h80;
    // Port 2 interface types: two CPU kinds, two handshake kinds
    localparam logic [1:0] MODE_CPU_A = 2'h0;
    localparam logic [1:0] MODE_CPU_B = 2'h1;
    // Bus configuration of a port
    typedef enum logic [1:0] {
        FPC_BUS_MUX_LOW,
        FPC_BUS_MUX_HIGH,
        FPC_BUS_NONMUX
    } fpc_bus_type;

    // One register access from a processor
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [3:0] hi_index;
        logic [7:0] wdata;
    } fpc_acc_type;

    // Port 2 simple I/O pins
    typedef struct packed {
        logic out3;
        logic out1;
        logic clr_out;
        logic clr_oe_b;
        logic dir_out;
        logic dir_oe_b;
    } fpc_p2io_type;
endpackage

// file: src/fpc_regs.sv
/*
 * Per-port control and status registers for both ports of a 128 byte dual-port buffer.
 * Assumes a processor on port 1 and a processor or handshake device on port 2,
 * both synchronous to clk; buffer storage is outside, only its pushes and pops arrive here.
 */
// Operation
// - Alignment bit clear: index from bus bits 1-4; set: bits 0-3
// - Nonmultiplexed bus forces alignment to 1; high-byte mode uses dedicated index pins
// - Soft reset bit holds block reset, controls cleared, port 2 floated
// - Control one clears on reset; bit 7 reads 0
// - Freeze holds byte count until its read completes, then auto-clears
// - Outgoing full sets on own message write, clears on peer read
// - Status bit mirrors peer in-service flag for messages
// - Stop-on-match drives request high on true pattern match
// - Start-on-count drives request low when count equals compare value
// - Select bit picks request or open-drain wait; enable gates pin, else float
// - Control two only on port 1; high bits zero; port 2 reads 00
// - Handshake enable gates port 2 handshake; clear forces strobe high
// - Port 2 floats and cannot program until port 1 enables it
// - Control three clears on reset; bit 2 reads 0; port 2 sees 3-0 zero
// - Clear ownership selects controlling port, or clear pin direction in I/O mode
// - Writing 0 to clear bit empties buffer; read-only for non-owner
// - Direction ownership selects controlling port, or direction pin direction in I/O mode
// - Direction 1 moves buffer to processor, 0 processor to buffer
// - In I/O mode bits 3,1 drive pins and bit 0 reads pin
// - Byte count is writes minus reads, at most 80 hex
// - Compare register up to 7F, bit 7 reads 0, compared continuously
// - Data byte compared with pattern, mask bits always match
// - Control zero bits 3,2 select port 2 interface type
`timescale 1ns/100ps
module fpc_regs #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire fpc_pkg::fpc_bus_type p1_bus,
    input wire fpc_pkg::fpc_bus_type p2_bus,
    input wire fpc_pkg::fpc_acc_type p1_acc,
    input wire fpc_pkg::fpc_acc_type p2_acc,
    output logic [7:0] p1_rdata,
    output logic [7:0] p2_rdata,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    input wire logic fifo_push,
    input wire logic fifo_pop,
    output logic fifo_clear,
    input wire logic p1_in_service,
    input wire logic p2_in_service,
    output logic p1_flow_out,
    output logic p1_flow_oe_b,
    output logic p2_flow_out,
    output logic p2_flow_oe_b,
    output logic port_two_handshake_strobe,
    output logic p2_float,
    output fpc_pkg::fpc_p2io_type p2io,
    input wire logic p2_in0,
    output logic p1_dir,
    output logic p2_dir,
    output logic [7:0] p1_count_match,
    output logic p1_pattern_match
);
    import fpc_pkg::*;

    // Per-port register set
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] msg_out;
        logic msg_full;
        logic [7:0] pattern;
        logic [7:0] mask;
        logic [7:0] fcmp;
        logic [7:0] frozen;
    } fpc_port_type;

    typedef struct packed {
        fpc_port_type [1:0] port;
        logic [7:0] ctrl2;
        logic [7:0] ctrl3;
        logic [7:0] count;
        logic [WIDTH-1:0] latch;
        logic [1:0][WIDTH-1:0] buf_d;
        logic [1:0] buf_v;
        logic buf_wp;
        logic buf_rp;
    } fpc_state_type;

    fpc_state_type state_r;
    fpc_state_type state_nxt;
    fpc_acc_type acc [2];
    fpc_bus_type bus [2];
    logic [3:0] idx [2];
    logic [1:0] acc_ok;
    logic [7:0] rdata [2];
    logic [1:0] match;
    logic [1:0] cnt_eq;
    logic p2_io_mode;
    logic soft_rst;
    logic push_in;
    logic pop_out;

    assign acc[0] = p1_acc;
    assign acc[1] = p2_acc;
    assign bus[0] = p1_bus;
    assign bus[1] = p2_bus;
    // Port 2 in a handshake interface type when mode bit 3 set
    assign p2_io_mode = state_r.port[0].ctrl0[C0_MODE_HI];
    assign soft_rst = state_r.port[0].ctrl0[C0_SOFT_RESET];

    // Index decode, access qualification, compare logic per port
    for (genvar p = 0; p < 2; p++) begin : g_port
        always_comb begin
            if (bus[p] == FPC_BUS_MUX_HIGH) begin
                idx[p] = acc[p].hi_index;
            end else if (bus[p] == FPC_BUS_NONMUX || state_r.port[p].ctrl0[C0_ALIGN]) begin
                idx[p] = acc[p].addr[3:0];
            end else begin
                idx[p] = acc[p].addr[4:1];
            end
        end
        // Port 2 needs enable and a CPU interface type
        if (p == 0) begin : g_ok1
            assign acc_ok[p] = 1'b1;
        end else begin : g_ok2
            assign acc_ok[p] = state_r.ctrl2[C2_P2_EN] && !p2_io_mode;
        end
        assign match[p] = &((state_r.latch ~^ state_r.port[p].pattern) | state_r.port[p].mask);
        assign cnt_eq[p] = (state_r.count == state_r.port[p].fcmp);
    end

    // Read multiplexer
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            rdata[p] = 8'h00;
            case (idx[p])
                REG_CTRL0: rdata[p] = state_r.port[p].ctrl0;
                REG_CTRL1: begin
                    rdata[p] = state_r.port[p].ctrl1 & C1_WMASK;
                    rdata[p][C1_MSG_FULL] = state_r.port[p].msg_full;
                    rdata[p][C1_PEER_IUS] = (p == 0) ? p2_in_service : p1_in_service;
                end
                REG_FCOUNT: rdata[p] = state_r.port[p].ctrl1[C1_FREEZE] ? state_r.port[p].frozen
                                                                         : state_r.count;
                REG_FCMP: rdata[p] = state_r.port[p].fcmp & FCMP_MASK;
                REG_CTRL2: rdata[p] = (p == 0) ? (state_r.ctrl2 & C2_MASK) : 8'h00;
                REG_CTRL3: begin
                    rdata[p] = state_r.ctrl3 & C3_MASK;
                    rdata[p][C3_IO0] = p2_io_mode & p2_in0;
                    if (p == 1) begin
                        rdata[p][3:0] = 4'h0;
                    end
                end
                REG_MSG_OUT: rdata[p] = state_r.port[p].msg_out;
                REG_MSG_IN: rdata[p] = state_r.port[1 - p].msg_out;
                REG_PATTERN: rdata[p] = state_r.port[p].pattern;
                REG_MASK: rdata[p] = state_r.port[p].mask;
                REG_DATA: rdata[p] = state_r.latch;
                default: rdata[p] = 8'h00;
            endcase
        end
    end

    // Two-entry buffer in the data path
    assign in_ready = !state_r.buf_v[state_r.buf_wp] && !soft_rst;
    assign out_valid = state_r.buf_v[state_r.buf_rp];
    assign push_in = in_valid && in_ready;
    assign pop_out = out_valid && out_ready;

    // Next-state logic
    always_comb begin
        logic own;
        own = 1'b0;
        state_nxt = state_r;
        // Buffer bookkeeping and data latch
        if (push_in) begin
            state_nxt.buf_d[state_r.buf_wp] = in_data;
            state_nxt.buf_v[state_r.buf_wp] = 1'b1;
            state_nxt.buf_wp = !state_r.buf_wp;
            state_nxt.latch = in_data;
        end
        if (pop_out) begin
            state_nxt.buf_v[state_r.buf_rp] = 1'b0;
            state_nxt.buf_rp = !state_r.buf_rp;
        end
        // Live byte count, saturating
        if (fifo_push && !fifo_pop && state_r.count < COUNT_MAX) begin
            state_nxt.count = state_r.count + 8'h01;
        end else if (fifo_pop && !fifo_push && state_r.count != 8'h00) begin
            state_nxt.count = state_r.count - 8'h01;
        end
        if (!state_r.ctrl3[C3_CLR_N]) begin
            state_nxt.count = 8'h00;
        end
        for (int p = 0; p < 2; p++) begin
            // Track count while not frozen
            if (!state_r.port[p].ctrl1[C1_FREEZE]) begin
                state_nxt.port[p].frozen = state_r.count;
            end
            if (acc[p].rd && acc_ok[p]) begin
                if (idx[p] == REG_FCOUNT) begin
                    state_nxt.port[p].ctrl1[C1_FREEZE] = 1'b0;
                end
                if (idx[p] == REG_MSG_IN) begin
                    state_nxt.port[1 - p].msg_full = 1'b0;
                end
            end
        end
        for (int p = 0; p < 2; p++) begin
            if (acc[p].wr && acc_ok[p]) begin
                case (idx[p])
                    REG_CTRL0: state_nxt.port[p].ctrl0 = acc[p].wdata;
                    REG_CTRL1: state_nxt.port[p].ctrl1 = acc[p].wdata & C1_WMASK;
                    REG_FCMP: state_nxt.port[p].fcmp = acc[p].wdata & FCMP_MASK;
                    REG_CTRL2: begin
                        if (p == 0) begin
                            state_nxt.ctrl2 = acc[p].wdata & C2_MASK;
                        end
                    end
                    REG_CTRL3: begin
                        own = state_r.ctrl3[C3_CLR_OWN];
                        if (p == 0) begin
                            state_nxt.ctrl3[7] = acc[p].wdata[7];
                            state_nxt.ctrl3[5] = acc[p].wdata[5];
                            state_nxt.ctrl3[3] = acc[p].wdata[3];
                            state_nxt.ctrl3[1:0] = acc[p].wdata[1:0] & 2'h2;
                        end
                        if (own == p[0]) begin
                            state_nxt.ctrl3[C3_CLR_N] = acc[p].wdata[C3_CLR_N];
                        end
                        if (state_r.ctrl3[C3_DIR_OWN] == p[0]) begin
                            state_nxt.ctrl3[C3_DIR] = acc[p].wdata[C3_DIR];
                        end
                    end
                    REG_MSG_OUT: begin
                        state_nxt.port[p].msg_out = acc[p].wdata;
                        state_nxt.port[p].msg_full = 1'b1;
                    end
                    REG_PATTERN: state_nxt.port[p].pattern = acc[p].wdata;
                    REG_MASK: state_nxt.port[p].mask = acc[p].wdata;
                    default: ;
                endcase
            end
            // Nonmultiplexed ports see alignment set, except while soft reset holds control zero cleared
            if (bus[p] == FPC_BUS_NONMUX) begin
                state_nxt.port[p].ctrl0[C0_ALIGN] = 1'b1;
            end
        end
        // Soft reset clears all control registers, keeping only itself
        if (state_nxt.port[0].ctrl0[C0_SOFT_RESET]) begin
            state_nxt.port[0].ctrl0 = 8'h01;
            state_nxt.port[1].ctrl0 = CTRL_RESET;
            state_nxt.port[0].ctrl1 = CTRL_RESET;
            state_nxt.port[1].ctrl1 = CTRL_RESET;
            state_nxt.ctrl2 = CTRL_RESET;
            state_nxt.ctrl3 = CTRL_RESET;
        end
    end

    // State register; pattern and mask may legitimately reset to zero here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Flow-control pin per port
    always_comb begin
        logic [1:0] req;
        req = 2'b11;
        for (int p = 0; p < 2; p++) begin
            req[p] = 1'b1;
            if (state_r.port[p].ctrl1[C1_START_CNT] && cnt_eq[p]) begin
                req[p] = 1'b0;
            end
            if (state_r.port[p].ctrl1[C1_STOP_MATCH] && match[p]) begin
                req[p] = 1'b1;
            end
        end
        p1_flow_out = state_r.port[0].ctrl1[C1_REQ_SEL] ? req[0] : 1'b0;
        p1_flow_oe_b = !(state_r.port[0].ctrl1[C1_FLOW_EN]
                         && (state_r.port[0].ctrl1[C1_REQ_SEL] || !req[0]));
        p2_flow_out = state_r.port[1].ctrl1[C1_REQ_SEL] ? req[1] : 1'b0;
        p2_flow_oe_b = !(state_r.port[1].ctrl1[C1_FLOW_EN] && !p2_float && !p2_io_mode
                         && (state_r.port[1].ctrl1[C1_REQ_SEL] || !req[1]));
    end

    // Port 2 pins, direction and clear
    assign p2_float = soft_rst || !state_r.ctrl2[C2_P2_EN];
    assign port_two_handshake_strobe = !(state_r.ctrl2[C2_HS_EN] && p2_io_mode) || out_valid;
    assign p2io.out3 = state_r.ctrl3[C3_IO3];
    assign p2io.out1 = state_r.ctrl3[C3_IO1];
    assign p2io.clr_out = state_r.ctrl3[C3_CLR_N];
    assign p2io.clr_oe_b = !(p2_io_mode && !state_r.ctrl3[C3_CLR_OWN] && !p2_float);
    assign p2io.dir_out = state_r.ctrl3[C3_DIR];
    assign p2io.dir_oe_b = !(p2_io_mode && !state_r.ctrl3[C3_DIR_OWN] && !p2_float);
    assign fifo_clear = !state_r.ctrl3[C3_CLR_N];
    // Direction 1 moves buffer toward the port 1 processor, whichever port owns direction
    assign p1_dir = state_r.ctrl3[C3_DIR];
    assign p2_dir = !state_r.ctrl3[C3_DIR];
    assign p1_count_match = {7'h00, cnt_eq[0]};
    assign p1_pattern_match = match[0];
    assign p1_rdata = rdata[0];
    assign p2_rdata = acc_ok[1] ? rdata[1] : 8'h00;
    assign out_data = state_r.buf_d[state_r.buf_rp];
endmodule // fpc_regs
